//--- rtl/dpwc_regs.svh
// field positions, reset values and timing constants of the wiper control
`ifndef DPWC_REGS_SVH
`define DPWC_REGS_SVH
// command byte fields
`define DPWC_SEL_HI     7
`define DPWC_SEL_LO     6
`define DPWC_TAP_HI     5
`define DPWC_SEL_CH0    2'h0
`define DPWC_SEL_CH1    2'h1
`define DPWC_SEL_CFG    2'h2
// configuration register bits and fixed upper bits of readback bytes
`define DPWC_CFG_TAPER  0
`define DPWC_CFG_ZC     1
`define DPWC_CFG_VOL    2
`define DPWC_CFG_RESET  3'h6
`define DPWC_CFG_TAG    5'h10
`define DPWC_WIPER_TAG  2'h0
// tap codes and attenuation in dB
`define DPWC_MUTE_OPT1  6'h3F
`define DPWC_MUTE_OPT2  6'h21
`define DPWC_OPT2_SEG1  6'h0C
`define DPWC_OPT2_SEG2  6'h18
`define DPWC_ATT_SEG2   7'h0C
`define DPWC_ATT_SEG3   7'h24
`define DPWC_ATT_STEP2  7'h02
`define DPWC_ATT_STEP3  7'h03
`define DPWC_ATT_MUTE   7'h5A
// gating window: milliseconds times kHz gives clock cycles
`define DPWC_WINDOW_MS  50
`define DPWC_CLK_KHZ    100000
`define DPWC_WINDOW_CYC (`DPWC_WINDOW_MS * `DPWC_CLK_KHZ)
`define DPWC_CNT_W      23
`define DPWC_TERM_W     8
`endif

//--- rtl/dpwc_pkg.sv
// shared types and taper arithmetic of the wiper control
`include "dpwc_regs.svh"
`default_nettype none
package dpwc_pkg;
    typedef logic [5:0]              dpwc_tap_t;
    typedef logic [6:0]              dpwc_db_t;
    typedef logic [`DPWC_TERM_W-1:0] dpwc_term_t;
    typedef logic [`DPWC_CNT_W-1:0]  dpwc_cnt_t;
    typedef enum logic {GATE_IDLE, GATE_WAIT} dpwc_gate_state_t;
    typedef enum logic [1:0] {NV_IDLE, NV_ARMED, NV_HOLD} dpwc_nv_state_t;

    typedef struct packed {
        dpwc_gate_state_t state;
        dpwc_tap_t        pending;
        dpwc_tap_t        applied;
        dpwc_cnt_t        count;
    } dpwc_gate_st_t;

    typedef struct packed {
        logic [2:0]     cfg;
        dpwc_tap_t      code0;
        dpwc_tap_t      code1;
        dpwc_nv_state_t nv;
        logic           nv_start;
        dpwc_db_t       att0;
        dpwc_db_t       att1;
    } dpwc_top_st_t;

    // legal tap range depends on the selected taper
    function automatic logic dpwc_code_ok(input dpwc_tap_t code, input logic taper);
        dpwc_code_ok = taper ? (code <= `DPWC_MUTE_OPT2) : 1'b1;
    endfunction

    // tap code to attenuation; one taper bit serves both channels
    function automatic dpwc_db_t dpwc_atten(input dpwc_tap_t code, input logic taper);
        dpwc_db_t c;
        c = {1'b0, code};
        if (!taper) begin
            dpwc_atten = (code == `DPWC_MUTE_OPT1) ? `DPWC_ATT_MUTE : c;
        end else if (code >= `DPWC_MUTE_OPT2) begin
            dpwc_atten = `DPWC_ATT_MUTE;
        end else if (code > `DPWC_OPT2_SEG2) begin
            dpwc_atten = `DPWC_ATT_SEG3 + `DPWC_ATT_STEP3 * (c - {1'b0, `DPWC_OPT2_SEG2});
        end else if (code > `DPWC_OPT2_SEG1) begin
            dpwc_atten = `DPWC_ATT_SEG2 + `DPWC_ATT_STEP2 * (c - {1'b0, `DPWC_OPT2_SEG1});
        end else begin
            dpwc_atten = c;
        end
    endfunction
endpackage
`default_nettype wire

//--- rtl/dpwc_zc_gate.sv
// one channel's pending tap code, zero-crossing wait and window timeout
`include "dpwc_regs.svh"
`default_nettype none
module dpwc_zc_gate #(
    parameter int unsigned WINDOW_CYCLES = `DPWC_WINDOW_CYC
) (
    input  wire logic                 clk_in,
    input  wire logic                 resetn_in,
    input  wire logic                 load_in,
    input  wire dpwc_pkg::dpwc_tap_t  code_in,
    input  wire logic                 zc_enable_in,
    input  wire dpwc_pkg::dpwc_term_t upper_in,
    input  wire dpwc_pkg::dpwc_term_t lower_in,
    output var  dpwc_pkg::dpwc_tap_t  applied_out,
    output logic                      busy_out
);
    import dpwc_pkg::*;

    localparam dpwc_cnt_t LAST = dpwc_cnt_t'(WINDOW_CYCLES - 1);

    dpwc_gate_st_t st;
    dpwc_gate_st_t next_st;
    logic          zero_cross;

    // terminals equal means no signal across the element
    assign zero_cross = (upper_in == lower_in);

    // a fresh load restarts the window, so the newest code always wins
    always_comb begin
        next_st = st;
        unique case (st.state)
            GATE_IDLE: next_st.count = '0;
            GATE_WAIT: begin
                next_st.count = st.count + 1'b1;
                if (zero_cross || st.count == LAST) begin
                    next_st.applied = st.pending;
                    next_st.state   = GATE_IDLE;
                end
            end
        endcase
        if (load_in) begin
            next_st.count = '0;
            if (zc_enable_in) begin
                next_st.pending = code_in;
                next_st.state   = GATE_WAIT;
            end else begin
                next_st.applied = code_in;
                next_st.state   = GATE_IDLE;
            end
        end
    end

    // wipers come up at mute
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st <= '{GATE_IDLE, `DPWC_MUTE_OPT1, `DPWC_MUTE_OPT1, '0};
        end else begin
            st <= next_st;
        end
    end

    assign applied_out = st.applied;
    assign busy_out    = (st.state == GATE_WAIT);

    // ********************************
    // checks
    // ********************************
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    AST_ZC_DIRECT: assert property (
        load_in && !zc_enable_in |=> applied_out == $past(code_in) && !busy_out)
        else $error("ungated load not applied next cycle");
    AST_ZC_APPLY: assert property (
        busy_out && zero_cross && !load_in |=> !busy_out && applied_out == $past(st.pending))
        else $error("zero crossing did not apply pending code");
    AST_ZC_TIMEOUT: assert property (
        busy_out && st.count == LAST && !load_in |=> !busy_out && applied_out == $past(st.pending))
        else $error("window expiry did not apply pending code");
    AST_ZC_HOLD: assert property (
        busy_out && !zero_cross && st.count != LAST && !load_in |=> $stable(applied_out) && busy_out)
        else $error("wiper moved before crossing or timeout");
    CVR_ZC_CROSS: cover property (busy_out && zero_cross && !load_in);
    CVR_ZC_EXPIRE: cover property (busy_out && st.count == LAST);
endmodule // dpwc_zc_gate
`default_nettype wire

//--- rtl/dpwc_top.sv
// command decode, configuration and taper control of the dual attenuator
`include "dpwc_regs.svh"
`default_nettype none
module dpwc_top #(
    parameter int unsigned WINDOW_CYCLES = `DPWC_WINDOW_CYC
) (
    input  wire logic                 clk_in,
    input  wire logic                 resetn_in,
    input  wire logic                 cmd_valid_in,
    input  wire logic [7:0]           cmd_byte_in,
    input  wire logic                 stop_in,
    input  wire dpwc_pkg::dpwc_term_t chan0_upper_terminal_in,
    input  wire dpwc_pkg::dpwc_term_t chan0_lower_terminal_in,
    input  wire dpwc_pkg::dpwc_term_t chan1_upper_terminal_in,
    input  wire dpwc_pkg::dpwc_term_t chan1_lower_terminal_in,
    output var  dpwc_pkg::dpwc_tap_t  wiper0_code_out,
    output var  dpwc_pkg::dpwc_tap_t  wiper1_code_out,
    output var  dpwc_pkg::dpwc_db_t   atten0_db_out,
    output var  dpwc_pkg::dpwc_db_t   atten1_db_out,
    output logic [7:0]                wiper0_reg_out,
    output logic [7:0]                wiper1_reg_out,
    output logic [7:0]                config_reg_out,
    output logic                      storage_mode_select_out,
    output logic                      zc_enable_out,
    output logic                      taper_select_out,
    output logic                      nv_write_start_out
);
    import dpwc_pkg::*;

    // ********************************
    // state and decode signals
    // ********************************
    dpwc_top_st_t st;
    dpwc_top_st_t next_st;

    logic [1:0]   sel;
    dpwc_tap_t    tap;
    logic         taper;
    logic         zc_on;
    logic         tap_ok;
    logic         load0;
    logic         load1;
    logic         cfg_wr;
    logic         accepted;
    logic         busy0;
    logic         busy1;
    logic         any_busy;

    // ********************************
    // command byte decode
    // ********************************

    // split the command byte into selector and tap code
    assign sel = cmd_byte_in[`DPWC_SEL_HI:`DPWC_SEL_LO];
    assign tap = cmd_byte_in[`DPWC_TAP_HI:0];

    // the live configuration steers the range check and the gating
    assign taper = st.cfg[`DPWC_CFG_TAPER];
    assign zc_on = st.cfg[`DPWC_CFG_ZC];

    // out-of-range codes are dropped rather than clamped
    assign tap_ok = dpwc_code_ok(tap, taper);

    // selector patterns; 11 matches nothing and is ignored
    assign load0    = cmd_valid_in && (sel == `DPWC_SEL_CH0) && tap_ok;
    assign load1    = cmd_valid_in && (sel == `DPWC_SEL_CH1) && tap_ok;
    assign cfg_wr   = cmd_valid_in && (sel == `DPWC_SEL_CFG);
    assign accepted = load0 || load1 || cfg_wr;
    assign any_busy = busy0 || busy1;

    // ********************************
    // per-channel gating
    // ********************************

    // the two channels wait for their own crossings independently
    dpwc_zc_gate #(
        .WINDOW_CYCLES (WINDOW_CYCLES)
    ) u_gate0 (
        .clk_in       (clk_in),
        .resetn_in    (resetn_in),
        .load_in      (load0),
        .code_in      (tap),
        .zc_enable_in (zc_on),
        .upper_in     (chan0_upper_terminal_in),
        .lower_in     (chan0_lower_terminal_in),
        .applied_out  (wiper0_code_out),
        .busy_out     (busy0)
    );

    dpwc_zc_gate #(
        .WINDOW_CYCLES (WINDOW_CYCLES)
    ) u_gate1 (
        .clk_in       (clk_in),
        .resetn_in    (resetn_in),
        .load_in      (load1),
        .code_in      (tap),
        .zc_enable_in (zc_on),
        .upper_in     (chan1_upper_terminal_in),
        .lower_in     (chan1_lower_terminal_in),
        .applied_out  (wiper1_code_out),
        .busy_out     (busy1)
    );

    // ********************************
    // next-state logic
    // ********************************

    // registers, attenuation readout and the store sequencer
    always_comb begin
        next_st          = st;
        next_st.nv_start = 1'b0;

        // stored codes are the readback value, not the applied one
        if (load0) begin
            next_st.code0 = tap;
        end
        if (load1) begin
            next_st.code1 = tap;
        end

        // only the three low bits carry function
        if (cfg_wr) begin
            next_st.cfg = cmd_byte_in[`DPWC_CFG_VOL:0];
        end

        // one taper bit maps both channels, so they never disagree
        next_st.att0 = dpwc_atten(wiper0_code_out, taper);
        next_st.att1 = dpwc_atten(wiper1_code_out, taper);

        // store waits for stop, then, if gating is on at the stop, for any wiper still pending
        unique case (st.nv)
            NV_IDLE: begin
                if (accepted) begin
                    next_st.nv = NV_ARMED;
                end
            end
            NV_ARMED: begin
                if (stop_in) begin
                    if (st.cfg[`DPWC_CFG_VOL]) begin
                        next_st.nv = NV_IDLE;
                    end else if (zc_on && any_busy) begin
                        next_st.nv = NV_HOLD;
                    end else begin
                        next_st.nv       = NV_IDLE;
                        next_st.nv_start = 1'b1;
                    end
                end
            end
            NV_HOLD: begin
                if (accepted) begin
                    next_st.nv = NV_ARMED; // a new write needs its own stop
                end else if (!any_busy) begin
                    next_st.nv       = NV_IDLE;
                    next_st.nv_start = 1'b1;
                end
            end
            default: next_st.nv = NV_IDLE;
        endcase
    end

    // ********************************
    // state register
    // ********************************

    // comes up volatile, gated, fine taper, both wipers at mute
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st <= '{`DPWC_CFG_RESET, `DPWC_MUTE_OPT1, `DPWC_MUTE_OPT1,
                    NV_IDLE, 1'b0, `DPWC_ATT_MUTE, `DPWC_ATT_MUTE};
        end else begin
            st <= next_st;
        end
    end

    // ********************************
    // outputs
    // ********************************

    // readback bytes carry fixed upper bits above the data: 00 on both wipers, 10000 on config
    assign wiper0_reg_out          = {`DPWC_WIPER_TAG, st.code0};
    assign wiper1_reg_out          = {`DPWC_WIPER_TAG, st.code1};
    assign config_reg_out          = {`DPWC_CFG_TAG, st.cfg};
    assign storage_mode_select_out = st.cfg[`DPWC_CFG_VOL];
    assign zc_enable_out           = st.cfg[`DPWC_CFG_ZC];
    assign taper_select_out        = st.cfg[`DPWC_CFG_TAPER];
    assign nv_write_start_out      = st.nv_start;
    assign atten0_db_out           = st.att0;
    assign atten1_db_out           = st.att1;

    // ********************************
    // checks
    // ********************************
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    // ignored and refused commands leave the registers alone
    AST_TOP_RSVD: assert property (
        cmd_valid_in && sel == 2'h3
        |=> $stable(config_reg_out) && $stable(wiper0_reg_out) && $stable(wiper1_reg_out))
        else $error("reserved command changed a register");

    AST_TOP_RANGE: assert property (
        cmd_valid_in && taper && tap > `DPWC_MUTE_OPT2 && !sel[1] |=> $stable(wiper0_reg_out))
        else $error("out-of-range code accepted");

    AST_TOP_RANGE1: assert property (
        cmd_valid_in && taper && tap > `DPWC_MUTE_OPT2 && sel == `DPWC_SEL_CH1
        |=> $stable(wiper1_reg_out))
        else $error("out-of-range code accepted on channel 1");

    // a write lands in its own register and nowhere else
    AST_TOP_CFG: assert property (
        cfg_wr |=> config_reg_out[`DPWC_CFG_VOL:0] == $past(cmd_byte_in[`DPWC_CFG_VOL:0]))
        else $error("configuration write not stored");

    AST_TOP_W0: assert property (
        load0 |=> wiper0_reg_out[`DPWC_TAP_HI:0] == $past(tap) && $stable(wiper1_reg_out))
        else $error("channel 0 code not stored");

    AST_TOP_W1: assert property (
        load1 |=> wiper1_reg_out[`DPWC_TAP_HI:0] == $past(tap) && $stable(wiper0_reg_out))
        else $error("channel 1 code not stored");

    AST_TOP_CFGBITS: assert property (
        cfg_wr
        |=> zc_enable_out == $past(cmd_byte_in[`DPWC_CFG_ZC])
        && taper_select_out == $past(cmd_byte_in[`DPWC_CFG_TAPER])
        && storage_mode_select_out == $past(cmd_byte_in[`DPWC_CFG_VOL]))
        else $error("configuration bits do not reach their outputs");

    AST_TOP_CFGHOLD: assert property (
        !cfg_wr
        |=> $stable(config_reg_out))
        else $error("configuration changed without a write");

    AST_TOP_W0HOLD: assert property (
        !load0
        |=> $stable(wiper0_reg_out))
        else $error("channel 0 code changed without a write");

    AST_TOP_W1HOLD: assert property (
        !load1
        |=> $stable(wiper1_reg_out))
        else $error("channel 1 code changed without a write");

    // with gating off the wiper follows the write in one cycle
    AST_TOP_NOGATE0: assert property (
        load0 && !zc_on
        |=> wiper0_code_out == $past(tap))
        else $error("ungated channel 0 did not move at once");

    AST_TOP_NOGATE1: assert property (
        load1 && !zc_on
        |=> wiper1_code_out == $past(tap))
        else $error("ungated channel 1 did not move at once");

    // attenuation tracks the applied code under the shared taper
    AST_TOP_ATT: assert property (
        ##1 atten0_db_out == dpwc_atten($past(wiper0_code_out), $past(taper))
        && atten1_db_out == dpwc_atten($past(wiper1_code_out), $past(taper)))
        else $error("attenuation does not follow code and taper");

    AST_TOP_FINE: assert property (
        !taper && wiper0_code_out != `DPWC_MUTE_OPT1
        |=> atten0_db_out == {1'b0, $past(wiper0_code_out)})
        else $error("fine taper is not one dB per code");

    AST_TOP_FMUTE: assert property (
        !taper && wiper1_code_out == `DPWC_MUTE_OPT1
        |=> atten1_db_out == `DPWC_ATT_MUTE)
        else $error("fine taper top code does not mute");

    AST_TOP_COARSE: assert property (
        taper && wiper0_code_out <= `DPWC_OPT2_SEG1
        |=> atten0_db_out == {1'b0, $past(wiper0_code_out)})
        else $error("coarse taper first segment is not one dB per code");

    AST_TOP_CMUTE: assert property (
        taper && wiper0_code_out == `DPWC_MUTE_OPT2
        |=> atten0_db_out == `DPWC_ATT_MUTE)
        else $error("coarse taper top code does not mute");

    // store sequencer: one pulse per write burst, held back while a gate waits if gating is on at the stop
    AST_TOP_NV: assert property (
        st.nv == NV_HOLD && any_busy |=> !nv_write_start_out)
        else $error("store started during a gating wait");

    AST_TOP_VOL: assert property (
        st.nv == NV_ARMED && stop_in && storage_mode_select_out |=> !nv_write_start_out)
        else $error("store started in volatile mode");

    // a stop with nothing waiting starts the store at once
    AST_TOP_NVGO: assert property (
        st.nv == NV_ARMED && stop_in && !storage_mode_select_out && !(zc_on && any_busy)
        |=> nv_write_start_out)
        else $error("store did not start after stop");

    AST_TOP_NVLATE: assert property (
        st.nv == NV_HOLD && !accepted && !any_busy
        |=> nv_write_start_out)
        else $error("store did not start once the gating wait ended");

    AST_TOP_NVPULSE: assert property (
        nv_write_start_out
        |=> !nv_write_start_out)
        else $error("store start wider than one cycle");

    AST_TOP_NVBARE: assert property (
        st.nv == NV_IDLE
        |=> !nv_write_start_out)
        else $error("store started without a preceding write");

    // main scenarios worth seeing at least once
    CVR_TOP_HOLD: cover property (st.nv == NV_HOLD ##1 nv_write_start_out);
    CVR_TOP_OPT2: cover property (taper && load0 && tap == `DPWC_MUTE_OPT2);
    CVR_TOP_CFG: cover property (cfg_wr ##1 !zc_enable_out);
endmodule // dpwc_top
`default_nettype wire

//--- verification/dpwc_master_model.sv
// behavioural serial bus master: acknowledged command bytes and stop conditions
`default_nettype none
module dpwc_master_model (
    input  wire logic       clk_in,
    output logic            cmd_valid_out,
    output logic [7:0]      cmd_byte_out,
    output logic            stop_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // bus idle at time zero
    initial begin
        cmd_valid_out = 1'b0;
        cmd_byte_out  = 8'h00;
        stop_out      = 1'b0;
    end

    // one acknowledged byte; top bits pick wiper 0, wiper 1 or config
    task automatic send_cmd(input logic [7:0] b);
        @(posedge clk_in);
        #1;
        cmd_valid_out = 1'b1;
        cmd_byte_out  = b;
        @(posedge clk_in);
        #1;
        cmd_valid_out = 1'b0;
        // released byte shows the inverse so a stale value never looks valid
        cmd_byte_out  = ~b;
    endtask

    // stop condition, one cycle wide
    task automatic send_stop();
        @(posedge clk_in);
        #1;
        stop_out = 1'b1;
        @(posedge clk_in);
        #1;
        stop_out = 1'b0;
    endtask
endmodule // dpwc_master_model
`default_nettype wire

//--- verification/dpwc_top_tb.sv
// self-checking bench for the dual attenuator command control
`default_nettype none
module dpwc_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import dpwc_pkg::*;

    // ****************************************
    // signals and instances
    // ****************************************
    localparam int unsigned WIN = 20; // short window keeps the run brief
    logic       clk_in    = 1'b0;
    logic       resetn_in;
    logic       cmd_valid;
    logic [7:0] cmd_byte;
    logic       stop;
    dpwc_term_t t0u;
    dpwc_term_t t0l;
    dpwc_term_t t1u;
    dpwc_term_t t1l;
    dpwc_tap_t  code0;
    dpwc_tap_t  code1;
    dpwc_db_t   att0;
    dpwc_db_t   att1;
    logic [7:0] reg0;
    logic [7:0] reg1;
    logic [7:0] cfg;
    logic       vol;
    logic       zc;
    logic       taper;
    logic       nv;
    int         error_cnt   = 0;
    int         checks_done = 0;
    int         cycles      = 0;
    int         nv_seen     = 0;
    int         base;
    localparam logic [5:0] CT [7] = '{6'h00, 6'h0C, 6'h0D, 6'h18, 6'h19, 6'h20, 6'h21};
    localparam logic [6:0] CD [7] = '{7'h00, 7'h0C, 7'h0E, 7'h24, 7'h27, 7'h3C, 7'h5A};
    localparam logic [5:0] FT [5] = '{6'h00, 6'h01, 6'h28, 6'h3E, 6'h3F};
    localparam logic [6:0] FD [5] = '{7'h00, 7'h01, 7'h28, 7'h3E, 7'h5A};

    always #5 clk_in = ~clk_in;

    dpwc_master_model mst_u (
        .clk_in        (clk_in),
        .cmd_valid_out (cmd_valid),
        .cmd_byte_out  (cmd_byte),
        .stop_out      (stop)
    );

    dpwc_top #(.WINDOW_CYCLES(WIN)) dut_u (
        .clk_in                  (clk_in),
        .resetn_in               (resetn_in),
        .cmd_valid_in            (cmd_valid),
        .cmd_byte_in             (cmd_byte),
        .stop_in                 (stop),
        .chan0_upper_terminal_in (t0u),
        .chan0_lower_terminal_in (t0l),
        .chan1_upper_terminal_in (t1u),
        .chan1_lower_terminal_in (t1l),
        .wiper0_code_out         (code0),
        .wiper1_code_out         (code1),
        .atten0_db_out           (att0),
        .atten1_db_out           (att1),
        .wiper0_reg_out          (reg0),
        .wiper1_reg_out          (reg1),
        .config_reg_out          (cfg),
        .storage_mode_select_out (vol),
        .zc_enable_out           (zc),
        .taper_select_out        (taper),
        .nv_write_start_out      (nv)
    );

    // ****************************************
    // helpers
    // ****************************************
    // store pulses are counted so late ones are not missed
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (nv === 1'b1) begin
            nv_seen <= nv_seen + 1;
        end
        if (cycles == 4000) begin
            error_cnt++;
            close_out();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic ticks(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic end_test(input string s);
        $display("test %s done, mismatches %0d", s, error_cnt);
    endtask

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial begin
        resetn_in = 1'b0;
        t0u       = 8'h10;
        t0l       = 8'h20;
        t1u       = 8'h30;
        t1l       = 8'h40;
        ticks(16);
        resetn_in = 1'b1;
        // reset state: fine taper, gating on, volatile, both muted
        check(cfg, 8'h86);
        check(8'({vol, zc, taper}), 8'h06);
        check(8'(code0), 8'h3F);
        check(reg1, 8'h3F);
        check(8'(att1), 8'h5A);
        end_test("reset");
        // gated change waits for equal terminals on its own channel
        mst_u.send_cmd(8'h05);
        check(reg0, 8'h05);
        ticks(3);
        check(8'(code0), 8'h3F);
        t0l = t0u;
        ticks(1);
        check(8'(code0), 8'h05);
        check(8'(code1), 8'h3F);
        ticks(1);
        check(8'(att0), 8'h05);
        t0l = 8'h20;
        end_test("crossing");
        // no crossing: the window runs out and the code applies anyway
        mst_u.send_cmd(8'h4A);
        check(reg1, 8'h0A);
        ticks(WIN - 1);
        check(8'(code1), 8'h3F);
        ticks(1);
        check(8'(code1), 8'h0A);
        end_test("timeout");
        // both channels wait; each applies at its own crossing only
        mst_u.send_cmd(8'h03);
        mst_u.send_cmd(8'h4C);
        t1u = 8'h55;
        t1l = 8'h55;
        ticks(1);
        check(8'(code1), 8'h0C);
        check(8'(code0), 8'h05);
        t0u = 8'h20;
        ticks(1);
        check(8'(code0), 8'h03);
        t0u = 8'h10;
        end_test("independent");
        // coarse taper, gating off: immediate moves, full breakpoint table
        mst_u.send_cmd(8'h81);
        check(cfg, 8'h81);
        check(8'({vol, zc, taper}), 8'h01);
        for (int i = 0; i < 7; i++) begin
            mst_u.send_cmd({2'b00, CT[i]});
            check(8'(code0), 8'(CT[i]));
            ticks(1);
            check(8'(att0), 8'(CD[i]));
        end
        mst_u.send_cmd(8'h54);
        ticks(1);
        check(8'(att1), 8'h1C);
        mst_u.send_cmd(8'h22);
        ticks(1);
        check(reg0, 8'h21);
        check(8'(code0), 8'h21);
        mst_u.send_cmd(8'h62);
        ticks(1);
        check(reg1, 8'h14);
        // back to the fine taper: both channels follow together
        mst_u.send_cmd(8'h80);
        ticks(1);
        check(8'(att0), 8'h21);
        check(8'(att1), 8'h14);
        for (int i = 0; i < 5; i++) begin
            mst_u.send_cmd({2'b01, FT[i]});
            check(8'(code1), 8'(FT[i]));
            ticks(1);
            check(8'(att1), 8'(FD[i]));
        end
        end_test("tapers");
        // reserved top bits change nothing
        mst_u.send_cmd(8'hC5);
        ticks(2);
        check(cfg, 8'h80);
        check(reg0, 8'h21);
        check(reg1, 8'h3F);
        end_test("reserved");
        // nonvolatile store: one pulse after stop, none for a bare stop
        mst_u.send_cmd(8'h01);
        mst_u.send_stop();
        check(8'(nv), 8'h01);
        ticks(1);
        check(8'(nv), 8'h00);
        base = nv_seen;
        mst_u.send_stop();
        ticks(3);
        check(8'(nv_seen - base), 8'h00);
        // with gating on the store waits for the pending wiper
        mst_u.send_cmd(8'h82);
        mst_u.send_cmd(8'h07);
        base = nv_seen;
        mst_u.send_stop();
        ticks(3);
        check(8'(nv_seen - base), 8'h00);
        ticks(WIN + 4);
        check(8'(nv_seen - base), 8'h01);
        check(8'(code0), 8'h07);
        // volatile mode never starts a store
        mst_u.send_cmd(8'h84);
        mst_u.send_cmd(8'h09);
        base = nv_seen;
        mst_u.send_stop();
        ticks(6);
        check(8'(nv_seen - base), 8'h00);
        check(8'(vol), 8'h01);
        end_test("store");
        // a second reset in mid-run brings back the power-up state
        resetn_in = 1'b0;
        ticks(2);
        resetn_in = 1'b1;
        check(cfg, 8'h86);
        check(reg0, 8'h3F);
        check(8'(code0), 8'h3F);
        check(8'(att0), 8'h5A);
        end_test("reset again");
        close_out();
    end
endmodule // dpwc_top_tb
`default_nettype wire
